// *** btcs_defs.vh ***
// btcs_defs.vh: register map, field positions and reset values for the
// buffer transfer timing and cascaded capture pin select block.
// assumes: included by bare name from the design files of this block.
`ifndef BTCS_DEFS_VH
`define BTCS_DEFS_VH

// ----------------------------------------------------------------------
// register offsets on the plain register port
// ----------------------------------------------------------------------
`define BTCS_ADDR_W 3
`define BTCS_OFF_TIMING_CH0 3'h0
`define BTCS_OFF_TIMING_CH3 3'h1
`define BTCS_OFF_TIMING_CH4 3'h2
`define BTCS_OFF_CASCADE_SEL 3'h3

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define BTCS_BIT_PAIR_E 2
`define BTCS_BIT_PAIR_B 1
`define BTCS_BIT_PAIR_A 0
`define BTCS_BIT_CH2B_TO_CH1 3
`define BTCS_BIT_CH2A_TO_CH1 2
`define BTCS_BIT_CH1B_TO_CH2 1
`define BTCS_BIT_CH1A_TO_CH2 0

// ----------------------------------------------------------------------
// writable masks and reset values
// ----------------------------------------------------------------------
`define BTCS_MASK_TIMING_CH0 8'h07
`define BTCS_MASK_TIMING_CH34 8'h03
`define BTCS_MASK_CASCADE 8'h0f
`define BTCS_RST_TIMING 8'h00
`define BTCS_RST_CASCADE 8'h00
`define BTCS_READ_UNMAPPED 8'h00

`endif

// *** btcs_pair_transfer.v ***
// btcs_pair_transfer.v: transfer strobe for one general/buffer pair.
// assumes: compare match and counter clear are one-cycle pulses from the
// channel's compare and counter logic, synchronous to the clock.
`default_nettype none

module btcs_pair_transfer
(
   input wire buffer_mode,
   input wire on_clear,
   input wire compare_match,
   input wire counter_clear,
   output wire transfer
);

   // 0 selects compare match, 1 selects counter clear
   assign transfer = buffer_mode & (on_clear ? counter_clear : compare_match);

endmodule // btcs_pair_transfer

`default_nettype wire

// *** btcs_transfer_capture.v ***
// btcs_transfer_capture.v: buffer transfer timing registers for channels
// 0, 3 and 4 and the cascaded capture pin select of channel 1.
// assumes: one clock, register port strobes one cycle long, capture pin
// edge pulses already qualified by the edge selection logic outside.
//
// Local design decisions: the register offsets and the plain strobed port.
`include "btcs_defs.vh"
`default_nettype none

// Function
// - reserved upper bits read zero
// - separate timing register for channels 0,3,4
// - bit2: E pair on match or clear
// - bit2 reserved in channels 3 and 4
// - bit1: B pair on match or clear
// - bit0: A pair on match or clear
// - cascade select only in channel 1
// - bit3 adds ch2 pin B to ch1 B
// - bit2 adds ch2 pin A to ch1 A
// - bit1 adds ch1 pin B to ch2 B
// - bit0 adds ch1 pin A to ch2 A
module btcs_transfer_capture
(
   input wire REF_CLK,
   input wire RST,
   input wire [`BTCS_ADDR_W-1:0] ADDR,
   input wire [7:0] WDATA,
   input wire WR,
   input wire RD,
   output wire [7:0] RDATA,
   input wire [2:0] BUF_MODE_AB,
   input wire BUF_MODE_E,
   input wire [2:0] CMP_MATCH_A,
   input wire [2:0] CMP_MATCH_B,
   input wire CMP_MATCH_E,
   input wire [2:0] CNT_CLEAR,
   output wire [2:0] XFER_A,
   output wire [2:0] XFER_B,
   output wire XFER_E,
   input wire CH1_PIN_A_EDGE,
   input wire CH1_PIN_B_EDGE,
   input wire CH2_PIN_A_EDGE,
   input wire CH2_PIN_B_EDGE,
   input wire CASCADE_ON,
   output wire CH1_A_CAPTURE,
   output wire CH1_B_CAPTURE,
   output wire CH2_A_CAPTURE,
   output wire CH2_B_CAPTURE
);

   // ----------------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------------
   reg [7:0] timing_q [0:2];
   reg [7:0] cascade_q;
   reg [7:0] rdata_q;
   reg [7:0] rdata_d;
   integer i;

   function [7:0] timing_mask;
      input integer ch;
      begin
         timing_mask = (ch == 0) ? `BTCS_MASK_TIMING_CH0 : `BTCS_MASK_TIMING_CH34;
      end
   endfunction

   function is_timing;
      input [`BTCS_ADDR_W-1:0] a;
      input integer ch;
      begin
         is_timing = (a == (`BTCS_OFF_TIMING_CH0 + ch[`BTCS_ADDR_W-1:0]));
      end
   endfunction

   // ----------------------------------------------------------------------
   // register writes
   // ----------------------------------------------------------------------
   always @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         for (i = 0; i < 3; i = i + 1)
         begin
            timing_q[i] <= `BTCS_RST_TIMING;
         end
         cascade_q <= `BTCS_RST_CASCADE;
      end
      else if (WR)
      begin
         for (i = 0; i < 3; i = i + 1)
         begin
            if (is_timing(ADDR, i))
            begin
               timing_q[i] <= WDATA & timing_mask(i);
            end
         end
         if (ADDR == `BTCS_OFF_CASCADE_SEL)
         begin
            cascade_q <= WDATA & `BTCS_MASK_CASCADE;
         end
      end
   end

   // ----------------------------------------------------------------------
   // register reads, data in the cycle after the strobe
   // ----------------------------------------------------------------------
   always @*
   begin
      rdata_d = `BTCS_READ_UNMAPPED;
      if (RD)
      begin
         case (ADDR)
            `BTCS_OFF_TIMING_CH0: rdata_d = timing_q[0];
            `BTCS_OFF_TIMING_CH3: rdata_d = timing_q[1];
            `BTCS_OFF_TIMING_CH4: rdata_d = timing_q[2];
            `BTCS_OFF_CASCADE_SEL: rdata_d = cascade_q;
            default: rdata_d = `BTCS_READ_UNMAPPED;
         endcase
      end
   end

   always @(posedge REF_CLK or posedge RST)
   begin
      if (RST)
      begin
         rdata_q <= 8'h00;
      end
      else
      begin
         rdata_q <= rdata_d;
      end
   end

   assign RDATA = rdata_q;

   // ----------------------------------------------------------------------
   // buffer transfer strobes; channel index 0,1,2 = channels 0,3,4
   // ----------------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1)
      begin : g_pair
         btcs_pair_transfer u_a
         (
            .buffer_mode(BUF_MODE_AB[g]),
            .on_clear(timing_q[g][`BTCS_BIT_PAIR_A]),
            .compare_match(CMP_MATCH_A[g]),
            .counter_clear(CNT_CLEAR[g]),
            .transfer(XFER_A[g])
         );
         btcs_pair_transfer u_b
         (
            .buffer_mode(BUF_MODE_AB[g]),
            .on_clear(timing_q[g][`BTCS_BIT_PAIR_B]),
            .compare_match(CMP_MATCH_B[g]),
            .counter_clear(CNT_CLEAR[g]),
            .transfer(XFER_B[g])
         );
      end
   endgenerate

   btcs_pair_transfer u_e
   (
      .buffer_mode(BUF_MODE_E),
      .on_clear(timing_q[0][`BTCS_BIT_PAIR_E]),
      .compare_match(CMP_MATCH_E),
      .counter_clear(CNT_CLEAR[0]),
      .transfer(XFER_E)
   );

   // ----------------------------------------------------------------------
   // cascaded capture conditions
   // ----------------------------------------------------------------------
   assign CH1_B_CAPTURE = CH1_PIN_B_EDGE |
      (CASCADE_ON & cascade_q[`BTCS_BIT_CH2B_TO_CH1] & CH2_PIN_B_EDGE);
   assign CH1_A_CAPTURE = CH1_PIN_A_EDGE |
      (CASCADE_ON & cascade_q[`BTCS_BIT_CH2A_TO_CH1] & CH2_PIN_A_EDGE);
   assign CH2_B_CAPTURE = CH2_PIN_B_EDGE |
      (CASCADE_ON & cascade_q[`BTCS_BIT_CH1B_TO_CH2] & CH1_PIN_B_EDGE);
   assign CH2_A_CAPTURE = CH2_PIN_A_EDGE |
      (CASCADE_ON & cascade_q[`BTCS_BIT_CH1A_TO_CH2] & CH1_PIN_A_EDGE);

endmodule // btcs_transfer_capture

`default_nettype wire

// *** btcs_transfer_capture_asserts.sv ***
// port checker for btcs_transfer_capture
// assumes: bound to the top module, RST async high
`include "btcs_defs.vh"
`default_nettype none
module btcs_chk
(
   input wire logic REF_CLK, RST, WR, RD, CASCADE_ON, CH1_PIN_A_EDGE, CH1_A_CAPTURE,
   input wire logic [`BTCS_ADDR_W-1:0] ADDR,
   input wire logic [7:0] WDATA, RDATA,
   input wire logic [2:0] BUF_MODE_AB, XFER_A, XFER_B
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   sequence wr_rd0;
      WR && ADDR == 3'h0 ##1 RD && ADDR == 3'h0;
   endsequence
   chk_ch0_resv: assert property ($past(RD && ADDR == 3'h0)
      |-> RDATA[7:3] == 5'h00) else $error("ch0 reserved bits");
   chk_ch34_resv: assert property ($past(RD && ADDR inside {3'h1, 3'h2})
      |-> RDATA[7:2] == 6'h00) else $error("ch3 ch4 reserved bits");
   chk_casc_resv: assert property ($past(RD && ADDR == 3'h3)
      |-> RDATA[7:4] == 4'h0) else $error("cascade reserved bits");
   chk_ch0_rdback: assert property (wr_rd0
      |=> RDATA == ($past(WDATA, 2) & 8'h07)) else $error("ch0 read back");
   chk_a_mode: assert property ((XFER_A & ~BUF_MODE_AB) == 3'h0)
      else $error("a transfer outside buffer mode");
   chk_b_mode: assert property ((XFER_B & ~BUF_MODE_AB) == 3'h0)
      else $error("b transfer outside buffer mode");
   chk_own_pin: assert property (CH1_PIN_A_EDGE |-> CH1_A_CAPTURE)
      else $error("own pin lost");
   chk_casc_off: assert property (!CASCADE_ON && !CH1_PIN_A_EDGE
      |-> !CH1_A_CAPTURE) else $error("capture without cause");
endmodule // btcs_chk
bind btcs_transfer_capture btcs_chk u_chk (.*);
`default_nettype wire

// *** tb.sv ***
// self-checking bench for btcs_transfer_capture
// assumes: design and checker files compiled first
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic REF_CLK = '0, RST = '1, WR = '0, RD = '0, CASCADE_ON = '0, BUF_MODE_E = '0;
   logic CMP_MATCH_E = '0, CH1_PIN_A_EDGE = '0, CH1_PIN_B_EDGE = '0;
   logic CH2_PIN_A_EDGE = '0, CH2_PIN_B_EDGE = '0;
   logic [2:0] ADDR = '0, BUF_MODE_AB = '0, CMP_MATCH_A = '0, CMP_MATCH_B = '0, CNT_CLEAR = '0;
   logic [7:0] WDATA = '0;
   logic [3:0] sel = '0;
   wire [7:0] RDATA;
   wire [2:0] XFER_A, XFER_B;
   wire XFER_E, CH1_A_CAPTURE, CH1_B_CAPTURE, CH2_A_CAPTURE, CH2_B_CAPTURE;
   int n_errors = 0, cmp_count = 0;
   logic [7:0] msk [8] = '{8'h07, 8'h03, 8'h03, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00};
   btcs_transfer_capture dut (.*);
   always #10 REF_CLK = ~REF_CLK;
   task automatic chk(string nm, logic [10:0] seen, exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wr(logic [2:0] a, logic [7:0] d);
      {ADDR, WDATA, WR, RD} <= {a, d, 2'h2};
      @(posedge REF_CLK);
   endtask
   task automatic rd(logic [2:0] a, logic [7:0] e);
      {ADDR, WR, RD} <= {a, 2'h1};
      @(posedge REF_CLK);
      RD <= '0;
      #1 chk("rdata", {3'h0, RDATA}, {3'h0, e});
      @(posedge REF_CLK);
      #1 chk("rdata idle", {3'h0, RDATA}, 11'h000);
   endtask
   // captures expected: own pin, plus the selected partner pin while cascaded
   task automatic hit(logic [2:0] m, c, logic [3:0] p, logic [6:0] e);
      {WR, CMP_MATCH_A, CMP_MATCH_B, CMP_MATCH_E, CNT_CLEAR} <= {1'h0, m, m, m[0], c};
      {CH2_PIN_B_EDGE, CH2_PIN_A_EDGE, CH1_PIN_B_EDGE, CH1_PIN_A_EDGE} <= p;
      #1 chk("outs", {XFER_E, XFER_B, XFER_A, CH2_B_CAPTURE, CH2_A_CAPTURE, CH1_B_CAPTURE,
         CH1_A_CAPTURE}, {e, p | ({4{CASCADE_ON}} & {sel[1] & p[1], sel[0] & p[0],
         sel[3] & p[3], sel[2] & p[2]})});
      @(posedge REF_CLK);
   endtask
   initial
   begin
      repeat (5) @(posedge REF_CLK);
      RST <= '0;
      @(posedge REF_CLK);
      for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
      for (int a = 0; a < 8; a++) wr(a[2:0], 8'hff);
      for (int a = 0; a < 8; a++) rd(a[2:0], msk[a]);
      wr(3'h1, 8'h04);
      rd(3'h1, 8'h00);
      wr(3'h2, 8'h04);
      rd(3'h2, 8'h00);
      rd(3'h0, 8'h07);
      wr(3'h0, 8'h5d);
      rd(3'h0, 8'h05);
      {BUF_MODE_AB, BUF_MODE_E} <= 4'hf;
      for (int s = 0; s < 2; s++)
      begin
         for (int a = 0; a < 3; a++) wr(a[2:0], {8{s[0]}});
         hit(3'h7, 3'h0, 4'h0, s ? 7'h00 : 7'h7f);
         hit(3'h0, 3'h7, 4'h0, s ? 7'h7f : 7'h00);
      end
      wr(3'h0, 8'h02);
      hit(3'h7, 3'h0, 4'h0, 7'h41);
      hit(3'h0, 3'h7, 4'h0, 7'h3e);
      wr(3'h0, 8'h04);
      hit(3'h0, 3'h7, 4'h0, 7'h76);
      hit(3'h7, 3'h0, 4'h0, 7'h09);
      {BUF_MODE_AB, BUF_MODE_E} <= 4'h0;
      hit(3'h7, 3'h7, 4'h0, 7'h00);
      for (int s = 0; s < 32; s++)
      begin
         CASCADE_ON <= s < 16;
         sel = s[3:0];
         wr(3'h3, {4'h0, s[3:0]});
         for (int k = 0; k < 4; k++)
            hit(3'h0, 3'h0, 4'h1 << k, 7'h00);
      end
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
